// File: include/flash_mode_consts.vh
`ifndef FLASH_MODE_CONSTS_VH
`define FLASH_MODE_CONSTS_VH

// Instruction opcodes seen on the single-line command phase.
`define OP_READ_SR1      8'h05
`define OP_READ_SR2      8'h35
`define OP_WRITE_STATUS  8'h01
`define OP_READ_BANK     8'h16
`define OP_WRITE_BANK    8'h17
`define OP_QUAD_IO_READ  8'heb

// Field positions and field values.
`define QE_BIT           1
`define BANK_4BYTE_BIT   7
`define MODE_HI_NIBBLE   4'ha
`define NIBBLE_ALL_ONES  4'hf

// Phase lengths in serial clocks, given as last count value; the reset pattern is a count of all-ones clocks.
`define BYTE_LAST        4'h7
`define TWO_BYTE_LAST    4'hf
`define ADDR3_LAST       4'h5
`define ADDR4_LAST       4'h7
`define MODE_LAST        4'h1
`define DUMMY_LAST       4'h3
`define RESET_PATTERN    4'h8

// Reset values.
`define SR1_RESET        8'h00
`define SR2_RESET        8'h00
`define BANK_RESET       8'h00

// Local register port offsets.
`define REG_SR1          2'h0
`define REG_SR2          2'h1
`define REG_BANK         2'h2
`define REG_STATE        2'h3

// Output enable patterns.
`define OE_NONE          4'h0
`define OE_SERIAL_OUT    4'h2
`define OE_QUAD          4'hf

`endif

// File: rtl/pin_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for pins that arrive from outside the core clock domain.
module pin_sync #(
  parameter WIDTH = 6
)
(
  input  wire             core_clk,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // The first stage feeds only the second stage, so metastability never reaches logic.
  // Both stages reset high, the idle level of select and the pulled-up lines; the serial clock bit idles low, so it falls once after reset.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta     <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// File: rtl/serial_flash_mode_control.v
`timescale 1ns/1ps
`include "flash_mode_consts.vh"
// Overview of operation
// [RL1] Hold and write-protect pins never disabled by quad enable.
// [RL2] Quad enable lives at status register 2 bit 1.
// [RL3] Opcode 05h returns status register 1.
// [RL4] Opcode 35h returns status register 2.
// [RL5] Write status 01h, second byte bit1 set, sets enable.
// [RL6] Same write with bit1 clear clears quad enable.
// [RL7] Mode byte upper nibble A enters continuous read.
// [RL8] Mode byte 00h leaves continuous mode after read.
// [RL9] Any non-A upper nibble leaves continuous mode.
// [RL10] Eight clocks of all ones force continuous exit.
// [RL11] No full quad command mode; opcodes always single-line.
// [RL12] Eight-bit volatile bank register, bit 7 selects 4-byte.
// [RL13] In 4-byte mode bank bits ignored, command supplies address.
// [RL14] Bank read 16h, write 17h with one byte.
// [RL15] Bank bits select 128 Mb segment in 3-byte mode.
// [RL16] Clearing bit 7 restores 3-byte addressing.
// [RL17] Bank register resets to zero.
module serial_flash_mode_control (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire        sck,
  input  wire        cs_n,
  input  wire [3:0]  quad_data_lines_in,
  output reg  [3:0]  quad_data_lines_out,
  output reg  [3:0]  quad_data_lines_oe,
  output reg         hold_asserted,
  output reg         wp_asserted,
  output reg         array_rd,
  output reg  [31:0] array_addr,
  input  wire [7:0]  array_rdata,
  input  wire [1:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output wire        quad_enable_bit,
  output wire        four_byte_mode,
  output reg         cont_read_mode
);

  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_CMD    = 4'h1;
  localparam [3:0] ST_RDREG  = 4'h2;
  localparam [3:0] ST_WRSR   = 4'h3;
  localparam [3:0] ST_WRBANK = 4'h4;
  localparam [3:0] ST_QADDR  = 4'h5;
  localparam [3:0] ST_QMODE  = 4'h6;
  localparam [3:0] ST_QDUMMY = 4'h7;
  localparam [3:0] ST_QDATA  = 4'h8;
  localparam [3:0] ST_IGNORE = 4'h9;

  wire [5:0]  pins_sync;
  wire        sck_s;
  wire        cs_s;
  wire [3:0]  dq_s;
  reg         sck_d;
  reg         cs_d;
  reg  [3:0]  state;
  reg  [3:0]  cnt;
  reg  [3:0]  ones_cnt;
  reg  [31:0] shift_in;
  reg  [7:0]  out_byte;
  reg  [31:0] rd_addr;
  reg         nib_low;
  reg         mode_keep;
  reg         mode_valid;
  reg  [7:0]  sr1;
  reg  [7:0]  sr2;
  reg  [7:0]  bank;
  wire        quad_phase;
  wire        sck_rise;
  wire        sck_fall;
  wire [7:0]  next_byte;
  wire [31:0] next_addr;
  wire [3:0]  addr_last;
  wire [3:0]  next_ones;

  // Applies the bank register to a raw address from the command.
  function [31:0] eff_addr;
    input [31:0] raw;
    input [7:0]  bank_reg;
    begin
      if (bank_reg[`BANK_4BYTE_BIT])
        eff_addr = raw; // [RL13]
      else
        eff_addr = {1'b0, bank_reg[6:0], raw[23:0]}; // [RL15] [RL16]
    end
  endfunction

  // All link pins, including the serial clock, pass two flops before use.
  pin_sync #(
    .WIDTH (6)
  ) u_pin_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in ({cs_n, sck, quad_data_lines_in}),
    .sync_out (pins_sync)
  );

  assign cs_s  = pins_sync[5];
  assign sck_s = pins_sync[4];
  assign dq_s  = pins_sync[3:0];

  // Clock edges count only inside a frame and while hold is not pausing the link.
  assign quad_phase = (state == ST_QADDR) || (state == ST_QMODE) || (state == ST_QDUMMY) || (state == ST_QDATA);
  assign sck_rise   = sck_s & ~sck_d & ~cs_s & ~hold_asserted;
  assign sck_fall   = ~sck_s & sck_d & ~cs_s & ~hold_asserted;
  assign next_byte  = {shift_in[6:0], dq_s[0]};
  assign next_addr  = {shift_in[27:0], dq_s};
  assign addr_last  = bank[`BANK_4BYTE_BIT] ? `ADDR4_LAST : `ADDR3_LAST;
  assign next_ones  = (dq_s == `NIBBLE_ALL_ONES) ? ones_cnt + 4'h1 : 4'h0;

  assign quad_enable_bit = sr2[`QE_BIT]; // [RL2]
  assign four_byte_mode  = bank[`BANK_4BYTE_BIT]; // [RL12]

  // Hold follows its pin while selected, and write protect follows its pin, whenever the lines are not carrying quad data.
  // Quad enable plays no part here, so those pin functions can never be switched off.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_asserted <= 1'b0;
      wp_asserted   <= 1'b0;
    end
    else
    begin
      hold_asserted <= ~quad_phase & ~cs_s & ~dq_s[3]; // [RL1]
      wp_asserted   <= ~quad_phase & ~dq_s[2]; // [RL1]
    end
  end

  // Local register port; read data stand only in the cycle after the strobe.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `REG_SR1:  reg_rdata <= sr1;
        `REG_SR2:  reg_rdata <= sr2;
        `REG_BANK: reg_rdata <= bank;
        default:   reg_rdata <= {5'h00, cont_read_mode, bank[`BANK_4BYTE_BIT], sr2[`QE_BIT]};
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // Frame sequencer and register writes from both the link and the local port.
  // Link writes come later in the process, so they win if both land in one cycle.
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sck_d               <= 1'b0;
      cs_d                <= 1'b1;
      state               <= ST_IDLE;
      cnt                 <= 4'h0;
      ones_cnt            <= 4'h0;
      shift_in            <= 32'h0000_0000;
      out_byte            <= 8'h00;
      rd_addr             <= 32'h0000_0000;
      nib_low             <= 1'b0;
      mode_keep           <= 1'b0;
      mode_valid          <= 1'b0;
      cont_read_mode      <= 1'b0;
      sr1                 <= `SR1_RESET;
      sr2                 <= `SR2_RESET;
      bank                <= `BANK_RESET; // [RL17]
      array_rd            <= 1'b0;
      array_addr          <= 32'h0000_0000;
      quad_data_lines_out <= 4'h0;
      quad_data_lines_oe  <= `OE_NONE;
    end
    else
    begin
      sck_d    <= sck_s;
      cs_d     <= cs_s;
      array_rd <= 1'b0;
      if (reg_wr)
      begin
        case (reg_addr)
          `REG_SR1:  sr1 <= reg_wdata;
          `REG_SR2:  sr2 <= reg_wdata;
          `REG_BANK: bank <= reg_wdata;
          default:   sr1 <= sr1;
        endcase
      end
      if (cs_s && !cs_d)
      begin
        // The mode byte of a finished read decides the next frame's form.
        state              <= ST_IDLE;
        quad_data_lines_oe <= `OE_NONE;
        if (mode_valid)
          cont_read_mode <= mode_keep; // [RL8] [RL9]
      end
      else if (!cs_s && cs_d)
      begin
        // A continuous read frame starts straight at the address.
        state      <= cont_read_mode ? ST_QADDR : ST_CMD;
        cnt        <= 4'h0;
        ones_cnt   <= 4'h0;
        shift_in   <= 32'h0000_0000;
        mode_valid <= 1'b0;
        nib_low    <= 1'b0;
      end
      else if (sck_rise)
      begin
        case (state)
          ST_CMD:
          begin
            // Opcodes are only ever taken one bit per clock on line 0.
            shift_in <= {24'h00_0000, next_byte}; // [RL11]
            cnt      <= cnt + 4'h1;
            if (cnt == `BYTE_LAST)
            begin
              cnt <= 4'h0;
              case (next_byte)
                `OP_READ_SR1:
                begin
                  out_byte <= sr1; // [RL3]
                  state    <= ST_RDREG;
                end
                `OP_READ_SR2:
                begin
                  out_byte <= sr2; // [RL4]
                  state    <= ST_RDREG;
                end
                `OP_READ_BANK:
                begin
                  out_byte <= bank; // [RL14]
                  state    <= ST_RDREG;
                end
                `OP_WRITE_STATUS: state <= ST_WRSR;
                `OP_WRITE_BANK:   state <= ST_WRBANK;
                `OP_QUAD_IO_READ: state <= sr2[`QE_BIT] ? ST_QADDR : ST_IGNORE; // [RL7]
                default:          state <= ST_IGNORE;
              endcase
            end
          end
          ST_WRSR:
          begin
            shift_in <= {24'h00_0000, next_byte};
            cnt      <= cnt + 4'h1;
            if (cnt == `BYTE_LAST)
              sr1 <= next_byte;
            if (cnt == `TWO_BYTE_LAST)
            begin
              sr2   <= next_byte; // [RL5] [RL6]
              state <= ST_IGNORE;
            end
          end
          ST_WRBANK:
          begin
            shift_in <= {24'h00_0000, next_byte};
            cnt      <= cnt + 4'h1;
            if (cnt == `BYTE_LAST)
            begin
              bank  <= next_byte; // [RL14] [RL12] [RL16]
              state <= ST_IGNORE;
            end
          end
          ST_QADDR:
          begin
            shift_in <= next_addr;
            ones_cnt <= next_ones;
            cnt      <= cnt + 4'h1;
            if (cont_read_mode && next_ones == `RESET_PATTERN)
            begin
              // The exit is applied at the end of the frame, so the mode never changes mid-frame.
              mode_keep  <= 1'b0; // [RL10]
              mode_valid <= 1'b1;
              state      <= ST_IGNORE;
            end
            else if (cnt == addr_last)
            begin
              rd_addr <= next_addr;
              cnt     <= 4'h0;
              state   <= ST_QMODE;
            end
          end
          ST_QMODE:
          begin
            shift_in <= next_addr;
            ones_cnt <= next_ones;
            cnt      <= cnt + 4'h1;
            if (cont_read_mode && next_ones == `RESET_PATTERN)
            begin
              mode_keep  <= 1'b0; // [RL10]
              mode_valid <= 1'b1;
              state      <= ST_IGNORE;
            end
            else if (cnt == `MODE_LAST)
            begin
              // Only an upper nibble of A keeps the next frame opcode-free.
              mode_keep  <= (next_addr[7:4] == `MODE_HI_NIBBLE); // [RL7] [RL8] [RL9]
              mode_valid <= 1'b1;
              cnt        <= 4'h0;
              state      <= ST_QDUMMY;
            end
          end
          ST_QDUMMY:
          begin
            cnt <= cnt + 4'h1;
            if (cnt == `DUMMY_LAST)
            begin
              array_rd   <= 1'b1;
              array_addr <= eff_addr(rd_addr, bank); // [RL13] [RL15]
              state      <= ST_QDATA;
            end
          end
          default:
            state <= state;
        endcase
      end
      else if (sck_fall)
      begin
        case (state)
          ST_RDREG:
          begin
            // The register byte repeats for as long as the host keeps clocking.
            quad_data_lines_out <= {2'b00, out_byte[7], 1'b0};
            quad_data_lines_oe  <= `OE_SERIAL_OUT;
            out_byte            <= {out_byte[6:0], out_byte[7]};
          end
          ST_QDATA:
          begin
            // The next byte is fetched after the low nibble leaves, well before it is needed.
            quad_data_lines_oe  <= `OE_QUAD;
            quad_data_lines_out <= nib_low ? array_rdata[3:0] : array_rdata[7:4];
            nib_low             <= ~nib_low;
            if (nib_low)
            begin
              rd_addr    <= rd_addr + 32'h0000_0001;
              array_rd   <= 1'b1;
              array_addr <= eff_addr(rd_addr + 32'h0000_0001, bank);
            end
          end
          default:
            quad_data_lines_oe <= `OE_NONE;
        endcase
      end
    end
  end

endmodule

// File: test/mode_props.sv
`timescale 1ns/1ps
// Checks the register port and mode outputs against their causes.
module mode_props (
  input wire       core_clk,
  input wire       arst_n,
  input wire       cs_n,
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire [3:0] quad_data_lines_oe,
  input wire       quad_enable_bit,
  input wire       four_byte_mode,
  input wire       cont_read_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  qe_write_a: assert property (reg_wr && reg_addr == 2'h1 |=> quad_enable_bit == $past(reg_wdata[1]))
    else $error("quad enable did not follow write");
  bank_write_a: assert property (reg_wr && reg_addr == 2'h2 |=> four_byte_mode == $past(reg_wdata[7]))
    else $error("address mode did not follow write");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  bank_read_a: assert property (reg_rd && reg_addr == 2'h2 |=> reg_rdata[7] == $past(four_byte_mode))
    else $error("bank read top bit wrong");
  state_read_a: assert property (reg_rd && reg_addr == 2'h3 |=>
    reg_rdata == {5'h00, $past(cont_read_mode), $past(four_byte_mode), $past(quad_enable_bit)})
    else $error("state read wrong");
  state_ro_a: assert property (reg_wr && reg_addr == 2'h3 |=> $stable(four_byte_mode) && $stable(quad_enable_bit))
    else $error("state register written");
  cont_needs_qe_a: assert property ($rose(cont_read_mode) |-> quad_enable_bit)
    else $error("continuous mode without quad enable");
  cont_exit_a: assert property ($fell(cont_read_mode) |-> cs_n && $past(cs_n))
    else $error("continuous mode left inside a frame");
  oe_idle_a: assert property (cs_n [*8] |-> quad_data_lines_oe == 4'h0)
    else $error("lines driven while deselected");
endmodule
bind serial_flash_mode_control mode_props mode_props_i (.core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .quad_data_lines_oe(quad_data_lines_oe), .quad_enable_bit(quad_enable_bit),
  .four_byte_mode(four_byte_mode), .cont_read_mode(cont_read_mode));

// File: test/spi_host_model.sv
`timescale 1ns/1ps
// Host side of the link: mode 0, 80 ns clock that stands low between frames.
module spi_host_model (
  output reg       sck,
  output reg       cs_n,
  output reg [3:0] host_out,
  output reg [3:0] host_oe,
  input wire [3:0] lines
);
  initial
  begin
    sck = 0;
    cs_n = 1;
    host_out = 4'hf;
    host_oe = 4'hf;
  end
  // One clock: data changes while low, sampled at the rise.
  task clk(input [3:0] v, input [3:0] en, output [3:0] s);
    begin
      host_out = v;
      host_oe = en;
      #20 sck = 1;
      s = lines;
      #40 sck = 0;
      #20;
    end
  endtask
  // Ends a frame and keeps write-protect and hold inactive meanwhile.
  task fin;
    begin
      #20 cs_n = 1;
      host_out = 4'hf;
      host_oe = 4'hf;
      #200;
    end
  endtask
  // Single-line byte on line0, MSB first; line1 is left to the device.
  task byte_x(input [7:0] b, output [7:0] r);
    integer i;
    reg [3:0] s;
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        clk({3'b110, b[i]}, 4'b1101, s);
        r[i] = s[1];
      end
    end
  endtask
  // Opcode plus n data bytes; r holds the last byte seen on line1.
  task frame(input [7:0] op, input [15:0] d, input integer n, output [7:0] r);
    integer k;
    begin
      cs_n = 0;
      #40;
      byte_x(op, r);
      for (k = n - 1; k >= 0; k = k - 1)
        byte_x(d[k*8+:8], r);
      fin;
    end
  endtask
  // Quad read; op low means the opcode is skipped in continuous mode.
  task quad(input op, input [31:0] a, input four, input [7:0] m, output [7:0] d);
    integer i;
    reg [3:0] s;
    reg [7:0] r;
    begin
      cs_n = 0;
      #40;
      if (op)
        byte_x(8'heb, r);
      for (i = four ? 7 : 5; i >= 0; i = i - 1)
        clk(a[i*4+:4], 4'hf, s);
      clk(m[7:4], 4'hf, s);
      clk(m[3:0], 4'hf, s);
      for (i = 0; i < 5; i = i + 1)
        clk(4'h0, 4'h0, s);
      d[7:4] = s;
      clk(4'h0, 4'h0, s);
      d[3:0] = s;
      fin;
    end
  endtask
  // Eight clocks of all ones at frame start force continuous exit.
  task mode_reset;
    reg [3:0] s;
    begin
      cs_n = 0;
      #40;
      repeat (8) clk(4'hf, 4'hf, s);
      fin;
    end
  endtask
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
`include "flash_mode_consts.vh"
// Bench with a host model on the link, an array stub and the register port.
module tb;
  reg         core_clk = 0;
  reg         arst_n = 0;
  reg  [1:0]  reg_addr = 2'h0;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr = 0;
  reg         reg_rd = 0;
  reg  [7:0]  array_rdata = 8'h00;
  reg  [31:0] last_addr = 32'h0;
  reg  [7:0]  r;
  integer     n_mismatch = 0;
  integer     n_compared = 0;
  wire        sck, cs_n, hold_asserted, wp_asserted, array_rd, quad_enable_bit, four_byte_mode, cont_read_mode;
  wire [3:0]  dq_out, dq_oe, host_out, host_oe, lines;
  wire [31:0] array_addr;
  wire [7:0]  reg_rdata;
  always #5 core_clk = ~core_clk;
  // Every data line has a pull-up, so a line nobody drives reads high.
  assign lines = (dq_oe & dq_out) | (~dq_oe & ~(host_oe & ~host_out));
  serial_flash_mode_control serial_flash_mode_control_i (.core_clk(core_clk), .arst_n(arst_n), .sck(sck),
    .cs_n(cs_n), .quad_data_lines_in(lines), .quad_data_lines_out(dq_out), .quad_data_lines_oe(dq_oe),
    .hold_asserted(hold_asserted), .wp_asserted(wp_asserted), .array_rd(array_rd), .array_addr(array_addr),
    .array_rdata(array_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .quad_enable_bit(quad_enable_bit), .four_byte_mode(four_byte_mode),
    .cont_read_mode(cont_read_mode));
  spi_host_model spi_host_model_i (.sck(sck), .cs_n(cs_n), .host_out(host_out), .host_oe(host_oe), .lines(lines));
  // Array stub: data is a function of the address, so a wrong address shows.
  always @(posedge core_clk)
    if (array_rd)
    begin
      array_rdata <= array_addr[7:0] ^ 8'h5a;
      last_addr <= array_addr;
    end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [1:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge core_clk);
      reg_wr <= 0;
      #1;
    end
  endtask
  task rd(input [1:0] a, output [7:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge core_clk);
      reg_rd <= 0;
      #1 d = reg_rdata;
    end
  endtask
  task t_reset;
    integer a;
    begin
      for (a = 0; a < 3; a = a + 1)
      begin
        rd(a[1:0], r);
        check(r, 8'h00);
      end
    end
  endtask
  task t_status;
    begin
      spi_host_model_i.frame(`OP_WRITE_STATUS, 16'h0002, 2, r);
      spi_host_model_i.frame(`OP_READ_SR2, 16'h0000, 1, r);
      check(r, 8'h02);
      spi_host_model_i.frame(`OP_READ_SR1, 16'h0000, 1, r);
      check(r, 8'h00);
      rd(`REG_SR2, r);
      check(r, 8'h02);
      spi_host_model_i.frame(`OP_WRITE_STATUS, 16'h0000, 2, r);
      check(quad_enable_bit, 1'b0);
      wr(`REG_SR2, 8'h02);
      check(quad_enable_bit, 1'b1);
    end
  endtask
  task t_wp;
    begin
      spi_host_model_i.host_out = 4'hb;
      repeat (6) @(posedge core_clk);
      check(wp_asserted, 1'b1);
      spi_host_model_i.host_out = 4'hf;
      repeat (6) @(posedge core_clk);
      check(wp_asserted, 1'b0);
    end
  endtask
  task t_bank;
    begin
      spi_host_model_i.frame(`OP_WRITE_BANK, 16'h0081, 1, r);
      check(four_byte_mode, 1'b1);
      spi_host_model_i.frame(`OP_READ_BANK, 16'h0000, 1, r);
      check(r, 8'h81);
      wr(`REG_STATE, 8'hff);
      rd(`REG_STATE, r);
      check(r, 8'h03);
      wr(`REG_BANK, 8'h00);
      check(four_byte_mode, 1'b0);
      wr(`REG_BANK, 8'h80);
    end
  endtask
  task t_quad;
    begin
      spi_host_model_i.quad(1, 32'h12345678, 1, 8'ha5, r);
      check(last_addr[31:8], 24'h123456);
      check(r, 8'h78 ^ 8'h5a);
      check(cont_read_mode, 1'b1);
      spi_host_model_i.quad(0, 32'h2a3b4c5d, 1, 8'h00, r);
      check(last_addr[31:8], 24'h2a3b4c);
      check(cont_read_mode, 1'b0);
      spi_host_model_i.frame(`OP_WRITE_BANK, 16'h0003, 1, r);
      spi_host_model_i.quad(1, 32'h00456789, 0, 8'ha0, r);
      check(last_addr[31:8], 24'h034567);
      check(cont_read_mode, 1'b1);
      spi_host_model_i.mode_reset;
      check(cont_read_mode, 1'b0);
      spi_host_model_i.quad(1, 32'h00111111, 0, 8'ha5, r);
      spi_host_model_i.quad(0, 32'h00222222, 0, 8'h5a, r);
      check(last_addr[31:8], 24'h032222);
      check(cont_read_mode, 1'b0);
    end
  endtask
  task final_report;
    begin
      $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Whole run takes well under 200 us; a hang is cut at 400 us.
  initial
  begin
    #400000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1;
    repeat (4) @(posedge core_clk);
    t_reset;
    t_status;
    t_wp;
    t_bank;
    t_quad;
    final_report;
  end
endmodule
